// ===== tb/cps_src.sv
// user-side cell source model for the policing selector bench
`timescale 1ns/100ps
`default_nettype none
module cps_src (
  // clock
  input wire logic mclk_in,
  // cell offer
  output logic cell_valid_out,
  input wire logic cell_ready_in,
  output logic [cps_pkg::CPS_CONN_W-1:0] cell_conn_out,
  output logic cell_clp_out,
  output logic [cps_pkg::CPS_DATA_W-1:0] cell_data_out
);
  import cps_pkg::*;
  initial begin
    cell_valid_out = 1'b0;
    cell_conn_out = 4'h0;
    cell_clp_out = 1'b0;
    cell_data_out = 8'h00;
  end
  // offer one cell, hold it until taken, then scramble the released lines
  task automatic send(input logic [CPS_CONN_W-1:0] conn, input logic clp, input logic [CPS_DATA_W-1:0] data);
    int n;
    n = 0;
    @(posedge mclk_in);
    cell_valid_out <= 1'b1;
    cell_conn_out <= conn;
    cell_clp_out <= clp;
    cell_data_out <= data;
    do begin
      @(posedge mclk_in);
      n++;
    end while (cell_ready_in !== 1'b1 && n < 200);
    // a cell never taken counts as a mismatch
    if (cell_ready_in !== 1'b1) tb_top.err_count++;
    cell_valid_out <= 1'b0;
    cell_conn_out <= ~conn;
    cell_clp_out <= ~clp;
    cell_data_out <= ~data;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the cell policing selector
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import cps_pkg::*;
  // ****
  // stimulus and observation
  // ****
  localparam logic [31:0] STRICT = 32'h0000_03e8;
  localparam logic [31:0] LAX = 32'h0000_0001;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cfg_we_in = 1'b0;
  logic [3:0] cfg_conn_in = 4'h0;
  cps_cat_t cfg_cat_in = CPS_CAT_VBR;
  logic [2:0] cfg_pol_in = 3'h5;
  logic cfg_ubr_tag_in = 1'b0;
  logic [31:0] cfg_pcr_inc_in = 32'h1, cfg_pcr_lim_in = 32'h0, cfg_scr_inc_in = 32'h1, cfg_scr_lim_in = 32'h0;
  logic cell_valid_in, cell_ready_out, cell_clp_in, cell_valid_out, cell_clp_out, cell_ubr_out;
  logic cell_ready_in = 1'b1;
  logic discard_out, tag_out;
  logic [3:0] cell_conn_in, cell_conn_out;
  logic [7:0] cell_data_in, cell_data_out;
  logic [3:0] conn_n = 4'h0;
  logic [13:0] outq[$];
  int n_disc = 0, n_tag = 0, err_count = 0, n_checks = 0;
  always #5 mclk_in = ~mclk_in;
  cps_top i_cps_top (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_we_in(cfg_we_in), .cfg_conn_in(cfg_conn_in),
    .cfg_cat_in(cfg_cat_in), .cfg_pol_in(cfg_pol_in), .cfg_ubr_tag_in(cfg_ubr_tag_in),
    .cfg_pcr_inc_in(cfg_pcr_inc_in), .cfg_pcr_lim_in(cfg_pcr_lim_in), .cfg_scr_inc_in(cfg_scr_inc_in),
    .cfg_scr_lim_in(cfg_scr_lim_in), .cell_valid_in(cell_valid_in), .cell_ready_out(cell_ready_out),
    .cell_conn_in(cell_conn_in), .cell_clp_in(cell_clp_in), .cell_data_in(cell_data_in),
    .cell_valid_out(cell_valid_out), .cell_ready_in(cell_ready_in), .cell_conn_out(cell_conn_out),
    .cell_clp_out(cell_clp_out), .cell_ubr_out(cell_ubr_out), .cell_data_out(cell_data_out),
    .discard_out(discard_out), .tag_out(tag_out));
  cps_src i_cps_src (.mclk_in(mclk_in), .cell_valid_out(cell_valid_in), .cell_ready_in(cell_ready_out),
    .cell_conn_out(cell_conn_in), .cell_clp_out(cell_clp_in), .cell_data_out(cell_data_in));
  // network side log of verdict pulses and delivered cells
  always @(posedge mclk_in) begin
    if (discard_out === 1'b1) n_disc <= n_disc + 1;
    if (tag_out === 1'b1) n_tag <= n_tag + 1;
    if (cell_valid_out === 1'b1 && cell_ready_in === 1'b1) begin
      outq.push_back({cell_ubr_out, cell_clp_out, cell_conn_out, cell_data_out});
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cfg(input logic [3:0] c, input cps_cat_t cat, input logic [2:0] pol, input logic tag,
                     input logic [31:0] pi, input logic [31:0] pl, input logic [31:0] si);
    @(posedge mclk_in);
    cfg_we_in <= 1'b1;
    cfg_conn_in <= c;
    cfg_cat_in <= cat;
    cfg_pol_in <= pol;
    cfg_ubr_tag_in <= tag;
    cfg_pcr_inc_in <= pi;
    cfg_pcr_lim_in <= pl;
    cfg_scr_inc_in <= si;
    @(posedge mclk_in);
    cfg_we_in <= 1'b0;
  endtask
  // fresh connection, one clean cell, then a too-close cell; expb 0 pass, 1 tag, 2 discard
  task automatic run_case(input cps_cat_t cat, input int pol, input logic tag, input logic [31:0] pi,
                          input logic [31:0] si, input logic clpb, input int expb);
    int d0, t0;
    logic u;
    u = (cat == CPS_CAT_UBR);
    conn_n = conn_n + 4'h1;
    cfg(conn_n, cat, 3'(pol), tag, pi, 32'h0, si);
    outq.delete();
    d0 = n_disc;
    t0 = n_tag;
    i_cps_src.send(conn_n, 1'b0, 8'h5a);
    i_cps_src.send(conn_n, clpb, 8'ha5);
    repeat (8) @(posedge mclk_in);
    chk("discard", n_disc - d0, expb == 2);
    chk("tag", n_tag - t0, expb == 1);
    chk("count", outq.size(), (expb == 2) ? 1 : 2);
    chk("first", outq[0], {u, u, conn_n, 8'h5a});
    if (expb != 2) chk("second", outq[1], {u, u | clpb | (expb == 1), conn_n, 8'ha5});
  endtask
  task automatic test_policing();
    cps_cat_t cats[2] = '{CPS_CAT_VBR, CPS_CAT_ABR};
    int ea[5] = '{2, 2, 2, 2, 0};
    int eb0[5] = '{2, 2, 1, 0, 0};
    int eb1[5] = '{2, 0, 0, 0, 0};
    foreach (cats[c]) begin
      for (int p = 1; p <= 5; p++) begin
        run_case(cats[c], p, 1'b0, STRICT, LAX, 1'b0, ea[p-1]);
        run_case(cats[c], p, 1'b0, LAX, STRICT, 1'b0, eb0[p-1]);
        run_case(cats[c], p, 1'b0, LAX, STRICT, 1'b1, eb1[p-1]);
      end
    end
    run_case(CPS_CAT_CBR, 4, 1'b0, STRICT, LAX, 1'b0, 2);
    run_case(CPS_CAT_CBR, 6, 1'b0, STRICT, STRICT, 1'b0, 0);
  endtask
  task automatic test_ubr();
    run_case(CPS_CAT_UBR, 1, 1'b0, STRICT, LAX, 1'b0, 2);
    run_case(CPS_CAT_UBR, 1, 1'b0, LAX, STRICT, 1'b0, 0);
    run_case(CPS_CAT_UBR, 5, 1'b1, LAX, STRICT, 1'b0, 1);
    run_case(CPS_CAT_UBR, 3, 1'b1, LAX, STRICT, 1'b1, 0);
    run_case(CPS_CAT_UBR, 5, 1'b1, STRICT, LAX, 1'b1, 2);
  endtask
  // late cell earns no credit: the cell right after it must still fail
  task automatic test_late();
    int d0;
    cfg(4'h0, CPS_CAT_VBR, CPS_POL_PEAK, 1'b0, 32'h14, 32'h4, LAX);
    outq.delete();
    d0 = n_disc;
    i_cps_src.send(4'h0, 1'b0, 8'h01);
    repeat (100) @(posedge mclk_in);
    i_cps_src.send(4'h0, 1'b0, 8'h02);
    i_cps_src.send(4'h0, 1'b0, 8'h03);
    repeat (30) @(posedge mclk_in);
    i_cps_src.send(4'h0, 1'b0, 8'h04);
    repeat (8) @(posedge mclk_in);
    chk("late_disc", n_disc - d0, 1);
    chk("late_cnt", outq.size(), 3);
    chk("late_last", outq[2], {6'h00, 8'h04});
  endtask
  // a later high-priority cell overtakes a waiting unspecified-rate cell
  task automatic test_order();
    cfg(4'h1, CPS_CAT_UBR, CPS_POL_OFF, 1'b0, LAX, 32'h0, LAX);
    cfg(4'h2, CPS_CAT_VBR, CPS_POL_OFF, 1'b0, LAX, 32'h0, LAX);
    outq.delete();
    @(posedge mclk_in);
    cell_ready_in <= 1'b0;
    i_cps_src.send(4'h2, 1'b0, 8'h11);
    i_cps_src.send(4'h1, 1'b0, 8'h22);
    i_cps_src.send(4'h2, 1'b0, 8'h33);
    repeat (6) @(posedge mclk_in);
    chk("held", outq.size(), 0);
    cell_ready_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    chk("order_cnt", outq.size(), 3);
    chk("order0", outq[0], {2'b00, 4'h2, 8'h11});
    chk("order1", outq[1], {2'b00, 4'h2, 8'h33});
    chk("order2", outq[2], {2'b11, 4'h1, 8'h22});
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (16) @(posedge mclk_in);
    chk("rdy_rst", cell_ready_out, 0);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk("rdy_run", cell_ready_out, 1);
    test_policing();
    test_ubr();
    test_late();
    test_order();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire

// ===== verilog/cps_bucket.sv
// one rate-conformance bucket with a theoretical arrival time per connection
`timescale 1ns/100ps
`default_nettype none
module cps_bucket #(
  parameter int CONN_W = cps_pkg::CPS_CONN_W,
  parameter int TIME_W = cps_pkg::CPS_TIME_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // per-connection setup
  input wire logic cfg_we_in,
  input wire logic [CONN_W-1:0] cfg_conn_in,
  input wire logic [TIME_W-1:0] cfg_inc_in,
  input wire logic [TIME_W-1:0] cfg_lim_in,
  // cell check
  input wire logic [CONN_W-1:0] conn_in,
  input wire logic [TIME_W-1:0] now_in,
  input wire logic check_in,
  input wire logic commit_in,
  output logic ok_out
);
  import cps_pkg::*;
  localparam int NCONN = 1 << CONN_W;

  logic [TIME_W-1:0] tat_q [NCONN];
  logic [TIME_W-1:0] inc_q [NCONN];
  logic [TIME_W-1:0] lim_q [NCONN];

  wire [TIME_W-1:0] tat_sel = tat_q[conn_in];
  wire [TIME_W-1:0] inc_sel = inc_q[conn_in];
  wire [TIME_W-1:0] diff = tat_sel - now_in;
  // late or on time: no credit carried over
  wire late = diff[TIME_W-1] || (diff == '0);
  wire early_ok = diff <= lim_q[conn_in];
  wire [TIME_W-1:0] tat_new = late ? (now_in + inc_sel) : (tat_sel + inc_sel);

  assign ok_out = late || early_ok;

  genvar g;
  generate
    for (g = 0; g < NCONN; g++) begin : g_entry
      always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          tat_q[g] <= CPS_TAT_RST;
          inc_q[g] <= CPS_INC_RST;
          lim_q[g] <= CPS_LIM_RST;
        end else if (cfg_we_in && cfg_conn_in == CONN_W'(g)) begin
          tat_q[g] <= CPS_TAT_RST;
          inc_q[g] <= cfg_inc_in;
          lim_q[g] <= cfg_lim_in;
        end else if (commit_in && conn_in == CONN_W'(g)) begin
          tat_q[g] <= tat_new;
        end
      end
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  a_late_pass: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    check_in && late |-> ok_out) else $error("late cell judged non-compliant");
  a_early_fail: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    check_in && !diff[TIME_W-1] && diff > lim_q[conn_in] |-> !ok_out) else $error("early cell judged compliant");
  a_tat_advance: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    commit_in && late && !cfg_we_in |=> tat_q[$past(conn_in)] == $past(now_in) + $past(inc_sel))
    else $error("arrival time not advanced from cell arrival");
endmodule
`default_nettype wire

// ===== verilog/cps_pkg.sv
// constants and types for the cell policing selector
package cps_pkg;
  localparam int CPS_CONN_W = 4;
  localparam int CPS_TIME_W = 32;
  localparam int CPS_DATA_W = 8;
  localparam int CPS_POL_W = 3;
  typedef enum logic [1:0] {CPS_CAT_CBR, CPS_CAT_VBR, CPS_CAT_ABR, CPS_CAT_UBR} cps_cat_t;
  localparam logic [CPS_POL_W-1:0] CPS_POL_DUAL = 3'h1;
  localparam logic [CPS_POL_W-1:0] CPS_POL_DUAL_CLP0 = 3'h2;
  localparam logic [CPS_POL_W-1:0] CPS_POL_DUAL_TAG = 3'h3;
  localparam logic [CPS_POL_W-1:0] CPS_POL_PEAK = 3'h4;
  localparam logic [CPS_POL_W-1:0] CPS_POL_OFF = 3'h5;
  localparam logic [CPS_POL_W-1:0] CPS_POL_RST = CPS_POL_OFF;
  localparam logic [CPS_TIME_W-1:0] CPS_TAT_RST = 32'h0000_0000;
  localparam logic [CPS_TIME_W-1:0] CPS_INC_RST = 32'h0000_0001;
  localparam logic [CPS_TIME_W-1:0] CPS_LIM_RST = 32'h0000_0000;
endpackage

// ===== verilog/cps_sched.sv
// two-slot output stage serving other traffic ahead of unspecified-rate cells
`timescale 1ns/100ps
`default_nettype none
module cps_sched #(
  parameter int CONN_W = cps_pkg::CPS_CONN_W,
  parameter int DATA_W = cps_pkg::CPS_DATA_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // from policer
  input wire logic push_in,
  input wire logic push_ubr_in,
  input wire logic [CONN_W-1:0] push_conn_in,
  input wire logic push_clp_in,
  input wire logic [DATA_W-1:0] push_data_in,
  output logic hi_free_out,
  output logic ubr_free_out,
  // toward network
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [CONN_W-1:0] out_conn_out,
  output logic out_clp_out,
  output logic out_ubr_out,
  output logic [DATA_W-1:0] out_data_out
);
  localparam int W = CONN_W + 1 + DATA_W;

  logic hi_full_q, ubr_full_q;
  logic [W-1:0] hi_q, ubr_q, out_q;

  wire [W-1:0] push_w = {push_conn_in, push_clp_in, push_data_in};
  wire out_free = !out_valid_out || out_ready_in;
  wire load_hi = out_free && hi_full_q;
  // unspecified-rate cell only when nothing else is waiting
  wire load_ubr = out_free && !hi_full_q && ubr_full_q;

  assign hi_free_out = !hi_full_q;
  assign ubr_free_out = !ubr_full_q;
  assign {out_conn_out, out_clp_out, out_data_out} = out_q;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hi_full_q <= 1'b0;
      ubr_full_q <= 1'b0;
      hi_q <= '0;
      ubr_q <= '0;
      out_q <= '0;
      out_valid_out <= 1'b0;
      out_ubr_out <= 1'b0;
    end else begin
      hi_full_q <= (hi_full_q && !load_hi) || (push_in && !push_ubr_in);
      ubr_full_q <= (ubr_full_q && !load_ubr) || (push_in && push_ubr_in);
      if (push_in && !push_ubr_in) hi_q <= push_w;
      if (push_in && push_ubr_in) ubr_q <= push_w;
      if (out_free) begin
        out_valid_out <= load_hi || load_ubr;
        out_ubr_out <= load_ubr;
        out_q <= load_hi ? hi_q : ubr_q;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_ubr_yield: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    hi_full_q && out_free |=> out_valid_out && !out_ubr_out) else $error("unspecified-rate cell served ahead");
endmodule
`default_nettype wire

// ===== verilog/cps_top.sv
// cell policing selector: per-connection dual bucket usage control
`timescale 1ns/100ps
`default_nettype none
module cps_top #(
  parameter int CONN_W = cps_pkg::CPS_CONN_W,
  parameter int TIME_W = cps_pkg::CPS_TIME_W,
  parameter int DATA_W = cps_pkg::CPS_DATA_W
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // connection setup
  input wire logic cfg_we_in,
  input wire logic [CONN_W-1:0] cfg_conn_in,
  input wire cps_pkg::cps_cat_t cfg_cat_in,
  input wire logic [cps_pkg::CPS_POL_W-1:0] cfg_pol_in,
  input wire logic cfg_ubr_tag_in,
  input wire logic [TIME_W-1:0] cfg_pcr_inc_in,
  input wire logic [TIME_W-1:0] cfg_pcr_lim_in,
  input wire logic [TIME_W-1:0] cfg_scr_inc_in,
  input wire logic [TIME_W-1:0] cfg_scr_lim_in,
  // cells from user side
  input wire logic cell_valid_in,
  output logic cell_ready_out,
  input wire logic [CONN_W-1:0] cell_conn_in,
  input wire logic cell_clp_in,
  input wire logic [DATA_W-1:0] cell_data_in,
  // cells toward network
  output logic cell_valid_out,
  input wire logic cell_ready_in,
  output logic [CONN_W-1:0] cell_conn_out,
  output logic cell_clp_out,
  output logic cell_ubr_out,
  output logic [DATA_W-1:0] cell_data_out,
  // verdict pulses
  output logic discard_out,
  output logic tag_out
);
  import cps_pkg::*;
  localparam int NCONN = 1 << CONN_W;

  // ****************************************
  // connection table
  // ****************************************
  cps_cat_t cat_q [NCONN];
  logic [CPS_POL_W-1:0] pol_q [NCONN];
  logic utag_q [NCONN];

  genvar g;
  generate
    for (g = 0; g < NCONN; g++) begin : g_conn
      always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cat_q[g] <= CPS_CAT_VBR;
          pol_q[g] <= CPS_POL_RST;
          utag_q[g] <= 1'b0;
        end else if (cfg_we_in && cfg_conn_in == CONN_W'(g)) begin
          cat_q[g] <= cfg_cat_in;
          pol_q[g] <= cfg_pol_in;
          utag_q[g] <= cfg_ubr_tag_in;
        end
      end
    end
  endgenerate

  // ****************************************
  // arrival clock and cell stage
  // ****************************************
  logic [TIME_W-1:0] now_q;
  logic s_valid_q, s_clp_q;
  logic [CONN_W-1:0] s_conn_q;
  logic [DATA_W-1:0] s_data_q;
  logic hi_free, ubr_free;

  wire cps_cat_t cat = cat_q[s_conn_q];
  wire [CPS_POL_W-1:0] pol = pol_q[s_conn_q];
  wire utag = utag_q[s_conn_q];
  wire is_ubr = cat == CPS_CAT_UBR;

  // ****************************************
  // bucket selection
  // ****************************************
  // categories other than unspecified share one selection decode
  wire sel_dual = !is_ubr && pol == CPS_POL_DUAL;
  wire sel_clp0 = !is_ubr && pol == CPS_POL_DUAL_CLP0;
  wire sel_tag = !is_ubr && pol == CPS_POL_DUAL_TAG;
  wire sel_peak = !is_ubr && pol == CPS_POL_PEAK;
  wire en1 = is_ubr || sel_dual || sel_clp0 || sel_tag || sel_peak;
  wire en2 = sel_dual || sel_clp0 || sel_tag || (is_ubr && utag);
  wire clp0_only = sel_clp0 || sel_tag || is_ubr;
  wire tag2 = sel_tag || is_ubr;
  wire check2 = en2 && (!clp0_only || !s_clp_q);

  wire ok1, ok2;
  wire fail1 = en1 && !ok1;
  wire fail2 = check2 && !ok2;
  // peak failures never tag; untagged sustained failures discard too
  wire discard_w = fail1 || (fail2 && !tag2);
  wire tag_w = !discard_w && fail2;
  wire slot_free = is_ubr ? ubr_free : hi_free;
  wire adv = s_valid_q && (discard_w || slot_free);
  wire push = adv && !discard_w;
  wire commit1 = adv && en1 && !discard_w;
  wire commit2 = adv && check2 && !discard_w && !fail2;
  wire peak_check = s_valid_q && en1;
  wire sust_check = s_valid_q && check2;
  wire out_clp = s_clp_q || tag_w || is_ubr;
  wire accept = cell_valid_in && cell_ready_out;
  wire s_valid_d = accept || (s_valid_q && !adv);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      now_q <= '0;
      s_valid_q <= 1'b0;
      s_conn_q <= '0;
      s_clp_q <= 1'b0;
      s_data_q <= '0;
      cell_ready_out <= 1'b0;
      discard_out <= 1'b0;
      tag_out <= 1'b0;
    end else begin
      now_q <= now_q + 1'b1;
      s_valid_q <= s_valid_d;
      cell_ready_out <= !s_valid_d;
      discard_out <= adv && discard_w;
      tag_out <= adv && tag_w;
      if (accept) begin
        s_conn_q <= cell_conn_in;
        s_clp_q <= cell_clp_in;
        s_data_q <= cell_data_in;
      end
    end
  end

  cps_bucket #(.CONN_W(CONN_W), .TIME_W(TIME_W)) u_peak (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .cfg_we_in(cfg_we_in),
    .cfg_conn_in(cfg_conn_in),
    .cfg_inc_in(cfg_pcr_inc_in),
    .cfg_lim_in(cfg_pcr_lim_in),
    .conn_in(s_conn_q),
    .now_in(now_q),
    .check_in(peak_check),
    .commit_in(commit1),
    .ok_out(ok1)
  );

  cps_bucket #(.CONN_W(CONN_W), .TIME_W(TIME_W)) u_sust (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .cfg_we_in(cfg_we_in),
    .cfg_conn_in(cfg_conn_in),
    .cfg_inc_in(cfg_scr_inc_in),
    .cfg_lim_in(cfg_scr_lim_in),
    .conn_in(s_conn_q),
    .now_in(now_q),
    .check_in(sust_check),
    .commit_in(commit2),
    .ok_out(ok2)
  );

  cps_sched #(.CONN_W(CONN_W), .DATA_W(DATA_W)) u_sched (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .push_in(push),
    .push_ubr_in(is_ubr),
    .push_conn_in(s_conn_q),
    .push_clp_in(out_clp),
    .push_data_in(s_data_q),
    .hi_free_out(hi_free),
    .ubr_free_out(ubr_free),
    .out_valid_out(cell_valid_out),
    .out_ready_in(cell_ready_in),
    .out_conn_out(cell_conn_out),
    .out_clp_out(cell_clp_out),
    .out_ubr_out(cell_ubr_out),
    .out_data_out(cell_data_out)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  a_pol1_both: assert property (s_valid_q && sel_dual |-> en1 && check2 && !tag_w)
    else $error("selection 1 bucket use wrong");
  a_pol2_clp0: assert property (s_valid_q && sel_clp0 |-> en1 && check2 == !s_clp_q && !tag_w)
    else $error("selection 2 bucket use wrong");
  a_pol3_tag: assert property (s_valid_q && sel_tag |-> en1 && check2 == !s_clp_q && tag_w == (fail2 && !fail1))
    else $error("selection 3 tagging wrong");
  a_pol4_peak: assert property (s_valid_q && sel_peak |-> en1 && !check2 && !tag_w)
    else $error("selection 4 sustained bucket active");
  a_pol5_off: assert property (s_valid_q && !is_ubr && pol == CPS_POL_OFF |-> !discard_w && !tag_w)
    else $error("selection 5 cell judged");
  a_abr_as_vbr: assert property (s_valid_q && cat == CPS_CAT_ABR
    |-> check2 == ((pol == CPS_POL_DUAL) || ((pol == CPS_POL_DUAL_CLP0 || pol == CPS_POL_DUAL_TAG) && !s_clp_q)))
    else $error("available-rate policing differs");
  a_ubr_peak: assert property (s_valid_q && is_ubr && !utag |-> en1 && !check2 && !tag_w)
    else $error("unspecified untagged policing wrong");
  a_ubr_tag: assert property (s_valid_q && is_ubr && utag |-> check2 == !s_clp_q && tag_w == (fail2 && !fail1))
    else $error("unspecified tagging wrong");
  a_ubr_clp: assert property (cell_valid_out && cell_ubr_out |-> cell_clp_out)
    else $error("unspecified cell left high priority");
  a_fail_action: assert property (adv && fail1 |=> discard_out && !tag_out ##1 !discard_out)
    else $error("peak failure not discarded");
  a_tag_forward: assert property (adv && tag_w |-> push ##1 tag_out)
    else $error("tagged cell not forwarded");

  // ****************************************
  // verdict action checks
  // ****************************************
  a_pol1_clp1: assert property (s_valid_q && sel_dual && s_clp_q |-> check2)
    else $error("selection 1 low-priority cell unchecked");
  a_pol1_disc: assert property (s_valid_q && sel_dual && fail2 |-> discard_w)
    else $error("selection 1 sustained failure kept");
  a_pol2_disc: assert property (s_valid_q && sel_clp0 && fail2 |-> discard_w)
    else $error("selection 2 sustained failure kept");
  a_pol2_clp1: assert property (s_valid_q && sel_clp0 && s_clp_q |-> !fail2)
    else $error("selection 2 low-priority cell checked");
  a_pol3_keep: assert property (s_valid_q && sel_tag && fail2 && !fail1 |-> !discard_w)
    else $error("selection 3 tagged cell dropped");
  a_pol3_clp1: assert property (s_valid_q && sel_tag && s_clp_q |-> !tag_w)
    else $error("selection 3 low-priority cell tagged");
  a_pol4_disc: assert property (s_valid_q && sel_peak && fail1 |-> discard_w)
    else $error("selection 4 peak failure kept");
  a_pol4_notag: assert property (s_valid_q && sel_peak |-> !fail2)
    else $error("selection 4 second bucket failed a cell");
  a_pol5_open: assert property (s_valid_q && !is_ubr && pol == CPS_POL_OFF |-> !en1 && !check2)
    else $error("selection 5 bucket enabled");
  a_abr_peak: assert property (s_valid_q && cat == CPS_CAT_ABR
    |-> en1 == (pol == CPS_POL_DUAL || pol == CPS_POL_DUAL_CLP0 || pol == CPS_POL_DUAL_TAG || pol == CPS_POL_PEAK))
    else $error("available-rate peak bucket use differs");
  a_ubr_peak_on: assert property (s_valid_q && is_ubr |-> en1)
    else $error("unspecified peak bucket off");
  a_ubr_notag: assert property (s_valid_q && is_ubr && !utag |-> !fail2 && !tag_w)
    else $error("unspecified second bucket active");
  a_ubr_fail_tag: assert property (s_valid_q && is_ubr && fail2 && !fail1 |-> tag_w && !discard_w)
    else $error("unspecified second failure not tagged");
  a_ubr_mark: assert property (push && is_ubr |-> out_clp)
    else $error("unspecified cell pushed high priority");
  a_pass_fwd: assert property (adv && !fail1 && !fail2 |-> push && !tag_w)
    else $error("compliant cell not forwarded as is");
  a_peak_drop: assert property (adv && fail1 |-> !push && !tag_w)
    else $error("peak failure forwarded");
  a_tag_clp: assert property (push && tag_w |-> out_clp)
    else $error("tagged cell kept high priority");
  a_clp_kept: assert property (push && !is_ubr && !tag_w |-> out_clp == s_clp_q)
    else $error("untagged cell priority changed");
  a_disc_pulse: assert property (adv && discard_w |=> discard_out)
    else $error("discard not reported");
  a_pulse_excl: assert property (!(discard_out && tag_out))
    else $error("cell both tagged and discarded");
  a_tag_pulse: assert property (tag_out |=> !tag_out)
    else $error("tag pulse stretched");

  // ****************************************
  // bucket update and stall checks
  // ****************************************
  logic [3:0] stall_cnt_q;
  wire stall = s_valid_q && !adv && cell_ready_in;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stall_cnt_q <= 4'h0;
    end else if (!stall) begin
      stall_cnt_q <= 4'h0;
    end else if (stall_cnt_q != 4'hf) begin
      stall_cnt_q <= stall_cnt_q + 4'h1;
    end
  end

  a_disc_no_adv: assert property (s_valid_q && discard_w |-> !commit1 && !commit2)
    else $error("discarded cell advanced a bucket");
  a_tag_keep_tat: assert property (s_valid_q && tag_w |-> !commit2)
    else $error("tagged cell advanced second bucket");
  a_pass_commit: assert property (adv && !discard_w |-> commit1 == en1 && commit2 == (check2 && !fail2))
    else $error("forwarded cell bucket update wrong");
  a_stage_hold: assert property (s_valid_q && !adv |=> s_valid_q && $stable(s_conn_q))
    else $error("stalled cell lost");
  a_stall_short: assert property (stall_cnt_q < 4'h3)
    else $error("cell stalled with network ready");

  c_tagged: cover property (adv && tag_w);
  c_discard: cover property (adv && discard_w);
  c_ubr_out: cover property (cell_valid_out && cell_ubr_out && cell_ready_in);
  c_pol_off: cover property (adv && !is_ubr && pol == CPS_POL_OFF);
  c_ubr_wait: cover property (cell_valid_out && cell_ready_in && !cell_ubr_out && !ubr_free);
endmodule
`default_nettype wire
